// ### hdl/sar_pkg.sv
// Constants and types shared by the shared-address register select block
package sar_pkg;

  // Bus geometry
  localparam int SAR_ADDR_W     = 14;  // APB byte address width
  localparam int SAR_IDX_W      = 12;  // Register index width
  localparam int SAR_DATA_W     = 32;  // APB data width
  localparam int SAR_REG_W      = 8;   // Width of every register
  localparam int SAR_NUM_SHARED = 9;   // Number of shared addresses

  // Register indices; byte address is four times the index
  localparam logic [11:0] SAR_IDX_OSC_REFO  = 12'hfd3;  // oscillator_control / reference_clock_output_control
  localparam logic [11:0] SAR_IDX_T1H_ODA   = 12'hfcf;  // timer1_count_high / open_drain_config_a
  localparam logic [11:0] SAR_IDX_T1L_ODB   = 12'hfce;  // timer1_count_low / open_drain_config_b
  localparam logic [11:0] SAR_IDX_T1C_ODC   = 12'hfcd;  // timer1_control / open_drain_config_c
  localparam logic [11:0] SAR_IDX_T2_PAD    = 12'hfcc;  // timer2_count / pad_config
  localparam logic [11:0] SAR_IDX_PR2_MEM   = 12'hfcb;  // timer2_period / external_memory_config
  localparam logic [11:0] SAR_IDX_AC0_APH   = 12'hfc2;  // analog_control_zero / analog_pin_config_high
  localparam logic [11:0] SAR_IDX_AC1_APL   = 12'hfc1;  // analog_control_one / analog_pin_config_low
  localparam logic [11:0] SAR_IDX_PR4_CVR   = 12'hf77;  // timer4_period / comparator_ref_control
  localparam logic [11:0] SAR_IDX_CTRL      = 12'hfc0;  // watchdog_regulator_control
  localparam logic [11:0] SAR_IDX_SERIAL    = 12'hfc8;  // serial_slave_address / mask
  localparam logic [11:0] SAR_IDX_PAR_HI    = 12'hf69;  // parallel_port_address_pair high byte
  localparam logic [11:0] SAR_IDX_PAR_LO    = 12'hf68;  // parallel_port_address_pair low byte

  // Shared index table, one entry per slot
  localparam logic [11:0] SAR_SHARED_IDX [SAR_NUM_SHARED] = '{
    SAR_IDX_OSC_REFO, SAR_IDX_T1H_ODA, SAR_IDX_T1L_ODB, SAR_IDX_T1C_ODC, SAR_IDX_T2_PAD,
    SAR_IDX_PR2_MEM, SAR_IDX_AC0_APH, SAR_IDX_AC1_APL, SAR_IDX_PR4_CVR};
  localparam int SAR_SLOT_MEM = 5;  // Slot whose alternate is the memory config

  // Control register field positions
  localparam int SAR_BIT_REG_LP = 7;  // regulator_low_power_enable
  localparam int SAR_BIT_SUPPLY = 6;  // core_supply_ok_status
  localparam int SAR_BIT_ALT    = 4;  // alt_register_select
  localparam int SAR_BIT_WDT    = 0;  // soft_watchdog_enable

  // Reset values
  localparam logic [7:0] SAR_REG_RST  = 8'h00;  // Shared and mode registers
  localparam logic       SAR_CTRL_RST = 1'b0;   // Control register writable bits

  // APB slave phase
  typedef enum logic [1:0] {
    SAR_IDLE   = 2'b00,
    SAR_ACCESS = 2'b01
  } sar_state_t;

  // Writable control bits as one carrier
  typedef struct packed {
    logic reg_lp;   // Regulator low-power enable
    logic alt_sel;  // Alternate register select
    logic wdt_en;   // Software watchdog enable
  } sar_ctrl_t;

endpackage : sar_pkg

// ### hdl/sar_top.sv
// APB register bank that routes shared addresses to default or alternate registers
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R01: Select bit one reaches alternate, zero default
// R02: Select bit changes only by software write
// R03: Select, low-power, watchdog bits reset to zero
// R04: Each shared address reaches exactly one register
// R05: Nine shared addresses with default/alternate pairs
// R06: Memory config alternate exists only on large variant
// R07: Serial mode picks slave address or mask
// R08: Parallel address and out-data share one pair
// R09: Mode-dependent pairs ignore the select bit
// R10: Software checks select bit before shared writes
// R11: Control bits 5 and 3-1 read zero
// R12: Bit 6 shows synchronised core supply status
// R13: Bits 7 and 0 drive regulator and watchdog
module sar_top #(
  parameter bit HAS_EXT_MEM = 1'b1  // Larger-package variant with memory config
) (
  input  wire logic                                ref_clk,
  input  wire logic                                reset,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [sar_pkg::SAR_ADDR_W-1:0]      paddr,
  input  wire logic [sar_pkg::SAR_DATA_W-1:0]      pwdata,
  output var  logic [sar_pkg::SAR_DATA_W-1:0]      prdata,
  output var  logic                                pready,
  output var  logic                                pslverr,
  input  wire logic                                core_supply_ok,
  input  wire logic                                serial_mask_mode,
  input  wire logic                                parallel_slave_mode,
  output var  logic                                regulator_low_power_enable,
  output var  logic                                soft_watchdog_enable,
  output var  logic                                alt_register_select,
  output var  logic [8*sar_pkg::SAR_NUM_SHARED-1:0] default_regs,
  output var  logic [8*sar_pkg::SAR_NUM_SHARED-1:0] alternate_regs,
  output var  logic [7:0]                          serial_slave_address,
  output var  logic [7:0]                          serial_slave_address_mask,
  output var  logic [15:0]                         parallel_port_address_pair
);

  // Bus phase and answer flops
  sar_pkg::sar_state_t state_q;        // APB slave phase
  sar_pkg::sar_ctrl_t  ctrl_q;         // Writable control bits
  logic [31:0]         prdata_q;       // Read data for access phase
  logic                pready_q;       // Access phase ready
  logic                pslverr_q;      // Unmapped address answer
  logic                supply_meta_q;  // Supply status first stage
  logic                supply_sync_q;  // Supply status second stage

  // Register storage
  logic [7:0] def_q [sar_pkg::SAR_NUM_SHARED];  // Default registers
  logic [7:0] alt_q [sar_pkg::SAR_NUM_SHARED];  // Alternate registers
  logic [7:0] ser_addr_q;                       // Serial slave address
  logic [7:0] ser_mask_q;                       // Serial slave address mask
  logic [15:0] par_pair_q;                      // Parallel port pair

  // Decode results
  logic [11:0]                       idx;        // Register index
  logic                              aligned;    // Word-aligned address
  logic [sar_pkg::SAR_NUM_SHARED-1:0] hit_sh;    // Shared slot hit
  logic                              hit_ctrl;   // Control register hit
  logic                              hit_ser;    // Serial register hit
  logic                              hit_phi;    // Parallel high byte hit
  logic                              hit_plo;    // Parallel low byte hit
  logic                              mapped;     // Any register hit
  logic [7:0]                        rd_byte;    // Selected read byte
  logic                              wr_go;      // Write takes effect
  logic [7:0]                        wbyte;      // Written byte

  // Index is the byte address divided by four
  // A byte address with low bits set matches nothing and is refused
  assign idx     = paddr[sar_pkg::SAR_ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wbyte   = pwdata[7:0];
  assign wr_go   = pready_q & psel & penable & pwrite & mapped;

  // Shared slot comparators, one per slot
  for (genvar g = 0; g < sar_pkg::SAR_NUM_SHARED; g++) begin : g_hit
    assign hit_sh[g] = aligned & (idx == sar_pkg::SAR_SHARED_IDX[g]);  // see R05
  end

  // Other register comparators
  always_comb begin
    hit_ctrl = aligned & (idx == sar_pkg::SAR_IDX_CTRL);
    hit_ser  = aligned & (idx == sar_pkg::SAR_IDX_SERIAL);
    hit_phi  = aligned & (idx == sar_pkg::SAR_IDX_PAR_HI);
    hit_plo  = aligned & (idx == sar_pkg::SAR_IDX_PAR_LO);
    mapped   = (|hit_sh) | hit_ctrl | hit_ser | hit_phi | hit_plo;
  end

  // Read multiplexer
  // Exactly one source is chosen per index; unmapped indices read zero
  // Mode-dependent pairs never look at the select bit; only the serial pair looks at its peripheral mode
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < sar_pkg::SAR_NUM_SHARED; i++) begin
      if (hit_sh[i]) begin
        // Only the selected member of the pair is visible
        rd_byte = ctrl_q.alt_sel ? alt_q[i] : def_q[i];  // see R01 see R04
      end
    end
    if (hit_ctrl) begin
      // Reserved bits stay zero
      rd_byte                         = 8'h00;  // see R11
      rd_byte[sar_pkg::SAR_BIT_REG_LP] = ctrl_q.reg_lp;
      rd_byte[sar_pkg::SAR_BIT_SUPPLY] = supply_sync_q;  // see R12
      rd_byte[sar_pkg::SAR_BIT_ALT]    = ctrl_q.alt_sel;
      rd_byte[sar_pkg::SAR_BIT_WDT]    = ctrl_q.wdt_en;
    end
    if (hit_ser) begin
      // Serial mode, not the select bit, picks the register
      rd_byte = serial_mask_mode ? ser_mask_q : ser_addr_q;  // see R07 see R09
    end
    if (hit_phi) begin
      rd_byte = par_pair_q[15:8];  // see R08 see R09
    end
    if (hit_plo) begin
      rd_byte = par_pair_q[7:0];  // see R08 see R09
    end
  end

  // APB phase tracking and answer
  // The answer is prepared at the setup edge so ready, data and error all leave flops
  // Costs no speed: every transfer completes in a single access cycle
  // Read data therefore reflect the select bit and serial mode as they stood at setup
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q   <= sar_pkg::SAR_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      case (state_q)
        sar_pkg::SAR_IDLE: begin
          if (psel && !penable) begin
            // Setup phase: prepare answer for next cycle
            state_q   <= sar_pkg::SAR_ACCESS;
            pready_q  <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q  <= (!pwrite && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
          end
        end
        sar_pkg::SAR_ACCESS: begin
          // One access cycle, then release
          state_q   <= sar_pkg::SAR_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
          prdata_q  <= 32'h0000_0000;
        end
        default: begin
          state_q  <= sar_pkg::SAR_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Core supply status synchroniser
  // The supply monitor is not on ref_clk; two stages keep metastability out of reads
  // Only the second stage feeds the read multiplexer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      supply_meta_q <= 1'b0;
      supply_sync_q <= 1'b0;
    end else begin
      supply_meta_q <= core_supply_ok;
      supply_sync_q <= supply_meta_q;  // see R12
    end
  end

  // Control register; only software writes change it
  // Hardware never touches these bits, so an access can never flip the select
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= '{default: sar_pkg::SAR_CTRL_RST};  // see R03
    end else if (wr_go && hit_ctrl) begin
      ctrl_q.reg_lp  <= wbyte[sar_pkg::SAR_BIT_REG_LP];  // see R13
      ctrl_q.alt_sel <= wbyte[sar_pkg::SAR_BIT_ALT];     // see R02
      ctrl_q.wdt_en  <= wbyte[sar_pkg::SAR_BIT_WDT];     // see R13
    end
  end

  assign regulator_low_power_enable = ctrl_q.reg_lp;
  assign soft_watchdog_enable       = ctrl_q.wdt_en;
  assign alt_register_select        = ctrl_q.alt_sel;

  // Shared register pairs, one per slot
  // The select bit gates each write enable, so one write never reaches both members
  // A missing alternate keeps its reset value and reads as zero
  for (genvar g = 0; g < sar_pkg::SAR_NUM_SHARED; g++) begin : g_pair
    localparam bit ALT_PRESENT = (g != sar_pkg::SAR_SLOT_MEM) || HAS_EXT_MEM;  // see R06

    // Default member takes writes while select is low
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        def_q[g] <= sar_pkg::SAR_REG_RST;
      end else if (wr_go && hit_sh[g] && !ctrl_q.alt_sel) begin
        def_q[g] <= wbyte;  // see R01 see R04
      end
    end

    // Alternate member takes writes while select is high
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        alt_q[g] <= sar_pkg::SAR_REG_RST;
      end else if (ALT_PRESENT && wr_go && hit_sh[g] && ctrl_q.alt_sel) begin
        alt_q[g] <= wbyte;  // see R01 see R04 see R06
      end
    end

    assign default_regs[8*g+:8]   = def_q[g];
    assign alternate_regs[8*g+:8] = alt_q[g];

    // One shared write changes at most one member of the pair
    pair_excl_a: assert property (@(posedge ref_clk) disable iff (reset) wr_go && hit_sh[g] |=> // see R04
      $stable(def_q[g]) || $stable(alt_q[g]))
      else $error("both members of a pair changed");
  end

  // Serial address and mask share one index
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ser_addr_q <= sar_pkg::SAR_REG_RST;
      ser_mask_q <= sar_pkg::SAR_REG_RST;
    end else if (wr_go && hit_ser) begin
      if (serial_mask_mode) begin
        ser_mask_q <= wbyte;  // see R07 see R09
      end else begin
        ser_addr_q <= wbyte;  // see R07 see R09
      end
    end
  end

  assign serial_slave_address      = ser_addr_q;
  assign serial_slave_address_mask = ser_mask_q;

  // Parallel pair: one physical register for both roles
  // The parallel port mode only renames the pair, so it plays no part in the decode
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      par_pair_q <= {sar_pkg::SAR_REG_RST, sar_pkg::SAR_REG_RST};
    end else if (wr_go && hit_phi) begin
      par_pair_q[15:8] <= wbyte;  // see R08
    end else if (wr_go && hit_plo) begin
      par_pair_q[7:0] <= wbyte;  // see R08
    end
  end

  assign parallel_port_address_pair = par_pair_q;

  // Checks on the routing and the bus answer
  // All checks sample on ref_clk; all but rst_ctrl_a stay silent while reset is held
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Write with select high lands only in the alternate
  alt_route_a: assert property (wr_go && hit_sh[0] && ctrl_q.alt_sel |=> // see R01
    alt_q[0] == $past(wbyte) && def_q[0] == $past(def_q[0]))
    else $error("alternate write misrouted");

  // Write with select low lands only in the default
  def_route_a: assert property (wr_go && hit_sh[3] && !ctrl_q.alt_sel |=> // see R04
    def_q[3] == $past(wbyte) && alt_q[3] == $past(alt_q[3]))
    else $error("default write misrouted");

  // Select bit moves only after a control write
  sel_hold_a: assert property ($changed(ctrl_q.alt_sel) |-> // see R02
    $past(wr_go) && $past(hit_ctrl))
    else $error("select bit changed without write");

  // Reserved control bits read zero
  rsv_zero_a: assert property (pready_q && $past(hit_ctrl && !pwrite) |-> // see R11
    prdata_q[5] == 1'b0 && prdata_q[3:1] == 3'h0)
    else $error("reserved control bit nonzero");

  // Status bit mirrors synchronised supply
  supply_bit_a: assert property (pready_q && $past(hit_ctrl && !pwrite) |-> // see R12
    prdata_q[6] == $past(supply_sync_q))
    else $error("supply status mismatch");

  // Watchdog and regulator outputs follow a control write
  ctrl_drive_a: assert property (wr_go && hit_ctrl |=> // see R13
    soft_watchdog_enable == $past(wbyte[0]) && regulator_low_power_enable == $past(wbyte[7]))
    else $error("control outputs not updated");

  // Serial mask mode writes only the mask
  ser_mode_a: assert property (wr_go && hit_ser && serial_mask_mode |=> // see R07
    ser_mask_q == $past(wbyte) && $stable(ser_addr_q))
    else $error("serial mode write misrouted");

  // Parallel reads ignore the select bit
  par_read_a: assert property (pready_q && $past(hit_phi && !pwrite) |-> // see R09
    prdata_q[7:0] == $past(par_pair_q[15:8]))
    else $error("parallel read wrong");

  // Memory config alternate takes writes only on the large variant
  mem_absent_a: assert property (wr_go && hit_sh[sar_pkg::SAR_SLOT_MEM] && ctrl_q.alt_sel |=> // see R06
    alt_q[sar_pkg::SAR_SLOT_MEM] == (HAS_EXT_MEM ? $past(wbyte) : sar_pkg::SAR_REG_RST))
    else $error("memory config alternate wrong");

  // Ready stands exactly one cycle after setup
  ready_pulse_a: assert property (psel && !penable && !pready_q |=> // see R04
    pready_q ##1 !pready_q)
    else $error("ready timing wrong");

  // Control write sets the select bit as written
  sel_write_a: assert property (wr_go && hit_ctrl |=> // see R02
    alt_register_select == $past(wbyte[sar_pkg::SAR_BIT_ALT]))
    else $error("select bit not updated");

  // Regulator and watchdog bits hold between control writes
  ctrl_hold_a: assert property (!(wr_go && hit_ctrl) |=> // see R13
    $stable(regulator_low_power_enable) && $stable(soft_watchdog_enable))
    else $error("control outputs changed without write");

  // Control bits come out of reset cleared
  rst_ctrl_a: assert property (@(posedge ref_clk) disable iff (1'b0) $fell(reset) |-> // see R03
    ctrl_q == '0 && !pready_q)
    else $error("control bits not cleared by reset");

  // Address mode writes only the slave address
  ser_addr_a: assert property (wr_go && hit_ser && !serial_mask_mode |=> // see R07
    ser_addr_q == $past(wbyte) && $stable(ser_mask_q))
    else $error("serial address write misrouted");

  // Serial reads follow the mode alone
  ser_read_a: assert property (pready_q && $past(hit_ser && !pwrite && !serial_mask_mode) |-> // see R09
    prdata_q[7:0] == $past(ser_addr_q))
    else $error("serial address read wrong");

  // Mask mode reads the mask register
  mask_read_a: assert property (pready_q && $past(hit_ser && !pwrite && serial_mask_mode) |-> // see R07
    prdata_q[7:0] == $past(ser_mask_q))
    else $error("serial mask read wrong");

  // High byte write keeps the low byte of the pair
  par_write_a: assert property (wr_go && hit_phi |=> // see R08
    parallel_port_address_pair[15:8] == $past(wbyte) && $stable(parallel_port_address_pair[7:0]))
    else $error("parallel high write wrong");

  // Low byte reads come from the same pair
  plo_read_a: assert property (pready_q && $past(hit_plo && !pwrite) |-> // see R08
    prdata_q[7:0] == $past(par_pair_q[7:0]))
    else $error("parallel low read wrong");

  // Shared reads show the member chosen at setup
  shared_read_a: assert property (pready_q && $past(hit_sh[2] && !pwrite) |-> // see R01
    prdata_q[7:0] == ($past(ctrl_q.alt_sel) ? $past(alt_q[2]) : $past(def_q[2])))
    else $error("shared read wrong");

  // Refused transfers return zero data
  unmapped_zero_a: assert property (pready_q && pslverr_q |-> // see R05
    prdata_q == 32'h0000_0000)
    else $error("refused transfer returned data");

  // Error answer only ever comes with ready
  err_ready_a: assert property (pslverr_q |-> pready_q) // see R05
    else $error("error without ready");

  // Writes answer with zero read data
  wr_rdata_a: assert property (pready_q && $past(psel && pwrite) |-> // see R04
    prdata_q == 32'h0000_0000)
    else $error("write returned data");

  // Main scenarios
  alt_write_c: cover property (wr_go && hit_sh[0] && ctrl_q.alt_sel);
  sel_toggle_c: cover property ($rose(ctrl_q.alt_sel) ##[1:20] wr_go && |hit_sh);
  mask_write_c: cover property (wr_go && hit_ser && serial_mask_mode);
  unmapped_c: cover property (pready_q && pslverr_q);
  par_slave_c: cover property (pready_q && $past(hit_plo && parallel_slave_mode));

endmodule : sar_top

`default_nettype wire

// ### bench/test_sar_top.sv
// Self-checking testbench for the shared-address register select block
`timescale 1ns/10ps
`default_nettype none
module test_sar_top;
  logic        ref_clk = 1'b0;        // System clock
  logic        reset   = 1'b1;        // Active-high reset
  logic        psel    = 1'b0;        // APB select
  logic        penable = 1'b0;        // APB access phase
  logic        pwrite  = 1'b0;        // APB direction
  logic [13:0] paddr   = 14'h0000;    // APB byte address
  logic [31:0] pwdata  = 32'h0;       // APB write data
  logic [31:0] prdata;                // APB read data
  logic        pready;                // APB ready
  logic        pslverr;               // APB error
  logic        sup_ok  = 1'b1;        // Core supply pin
  logic        ser_m   = 1'b0;        // Serial mask mode
  logic        par_m   = 1'b0;        // Parallel slave mode
  logic        lp_en, wdt_en, alt_sel; // Control outputs
  logic [71:0] dflt, altr;            // Shared register banks
  logic [7:0]  s_adr, s_msk;          // Serial registers
  logic [15:0] p_pair;                // Parallel pair
  int          error_cnt = 0;         // Mismatches
  int          samples_checked = 0;   // Comparisons
  int          cyc = 0;               // Cycle count for timeout
  logic [31:0] seed = 32'h3c7d;       // Random seed

  sar_top dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_supply_ok(sup_ok), .serial_mask_mode(ser_m), .parallel_slave_mode(par_m),
    .regulator_low_power_enable(lp_en), .soft_watchdog_enable(wdt_en), .alt_register_select(alt_sel),
    .default_regs(dflt), .alternate_regs(altr), .serial_slave_address(s_adr),
    .serial_slave_address_mask(s_msk), .parallel_port_address_pair(p_pair));

  // Clock generation
  always #10 ref_clk = ~ref_clk;

  // Verdict and end of run
  task automatic wrap_up;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // Word comparison
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // Single-bit comparison
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  // Expected control read back from a written byte and the supply level
  function automatic logic [31:0] exp_ctrl(input logic [7:0] w, input logic s);
    return {24'h0, w[7], s, 1'b0, w[4], 3'b000, w[0]};
  endfunction : exp_ctrl

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Main sequence
  initial begin
    logic [31:0] rd;
    logic        er;
    logic [7:0]  dv [9];
    logic [7:0]  av [9];
    logic [7:0]  cw, a, b;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    apb(0, sar_pkg::SAR_IDX_CTRL, 8'h00, rd, er);
    chk_word(rd, exp_ctrl(8'h00, 1'b1));
    chk_bit(alt_sel, 1'b0);
    // Default then alternate write at every shared index
    for (int k = 0; k < 9; k++) begin
      dv[k] = (k == 0) ? 8'hff : $random(seed);
      av[k] = (k == 0) ? 8'h00 : $random(seed);
      apb(1, sar_pkg::SAR_IDX_CTRL, 8'h00, rd, er);
      apb(0, sar_pkg::SAR_IDX_CTRL, 8'h00, rd, er);
      chk_bit(rd[4], 1'b0);
      apb(1, sar_pkg::SAR_SHARED_IDX[k], dv[k], rd, er);
      apb(1, sar_pkg::SAR_IDX_CTRL, 8'h10, rd, er);
      apb(0, sar_pkg::SAR_IDX_CTRL, 8'h00, rd, er);
      chk_bit(rd[4], 1'b1);
      apb(1, sar_pkg::SAR_SHARED_IDX[k], av[k], rd, er);
    end
    // Alternate view, select left set after many accesses
    for (int k = 0; k < 9; k++) begin
      apb(0, sar_pkg::SAR_SHARED_IDX[k], 8'h00, rd, er);
      chk_word(rd, {24'h0, av[k]});
      chk_word({24'h0, altr[8*k +: 8]}, {24'h0, av[k]});
    end
    chk_bit(alt_sel, 1'b1);
    apb(1, sar_pkg::SAR_IDX_CTRL, 8'h00, rd, er);
    for (int k = 0; k < 9; k++) begin
      apb(0, sar_pkg::SAR_SHARED_IDX[k], 8'h00, rd, er);
      chk_word(rd, {24'h0, dv[k]});
      chk_word({24'h0, dflt[8*k +: 8]}, {24'h0, dv[k]});
    end
    // Control byte: all ones, then random values
    for (int i = 0; i < 4; i++) begin
      cw = (i == 0) ? 8'hff : $random(seed);
      apb(1, sar_pkg::SAR_IDX_CTRL, cw, rd, er);
      apb(0, sar_pkg::SAR_IDX_CTRL, 8'h00, rd, er);
      chk_word(rd, exp_ctrl(cw, 1'b1));
      chk_bit(lp_en, cw[7]);
      chk_bit(wdt_en, cw[0]);
      chk_bit(alt_sel, cw[4]);
    end
    // Supply status follows the pin
    sup_ok <= 1'b0;
    repeat (4) @(posedge ref_clk);
    apb(0, sar_pkg::SAR_IDX_CTRL, 8'h00, rd, er);
    chk_word(rd, exp_ctrl(cw, 1'b0));
    sup_ok <= 1'b1;
    // Serial address and mask chosen by mode only
    a = $random(seed);
    b = $random(seed);
    apb(1, sar_pkg::SAR_IDX_CTRL, 8'h10, rd, er);
    ser_m <= 1'b0;
    apb(1, sar_pkg::SAR_IDX_SERIAL, a, rd, er);
    ser_m <= 1'b1;
    apb(1, sar_pkg::SAR_IDX_SERIAL, b, rd, er);
    apb(1, sar_pkg::SAR_IDX_CTRL, 8'h00, rd, er);
    apb(0, sar_pkg::SAR_IDX_SERIAL, 8'h00, rd, er);
    chk_word(rd, {24'h0, b});
    ser_m <= 1'b0;
    apb(0, sar_pkg::SAR_IDX_SERIAL, 8'h00, rd, er);
    chk_word(rd, {24'h0, a});
    chk_word({16'h0, s_adr, s_msk}, {16'h0, a, b});
    // Parallel pair: one store whatever the mode
    par_m <= 1'b0;
    apb(1, sar_pkg::SAR_IDX_PAR_HI, b, rd, er);
    apb(1, sar_pkg::SAR_IDX_PAR_LO, a, rd, er);
    par_m <= 1'b1;
    apb(1, sar_pkg::SAR_IDX_CTRL, 8'h10, rd, er);
    apb(0, sar_pkg::SAR_IDX_PAR_HI, 8'h00, rd, er);
    chk_word(rd, {24'h0, b});
    apb(0, sar_pkg::SAR_IDX_PAR_LO, 8'h00, rd, er);
    chk_word(rd, {24'h0, a});
    chk_word({16'h0, p_pair}, {16'h0, b, a});
    // Unmapped index is refused
    apb(1, 12'h000, 8'h5a, rd, er);
    chk_bit(er, 1'b1);
    apb(0, 12'h000, 8'h00, rd, er);
    chk_bit(er, 1'b1);
    chk_word(rd, 32'h0);
    wrap_up();
  end
endmodule : test_sar_top
`default_nettype wire
